// >>> verilog/dior_router.sv
`timescale 1ns/1ps
module dior_router (
  input logic sys_clk_i,
  input logic rst_b_i,
  input logic [1:0] din_i,
  input dior_pkg::dior_in_mode_t din_mode_0_i,
  input dior_pkg::dior_in_mode_t din_mode_1_i,
  input dior_pkg::dior_out_sel_t dout_sel_0_i,
  input dior_pkg::dior_out_sel_t dout_sel_1_i,
  input logic [15:0] pulse_width_i,
  input logic [15:0] pulse_delay_0_i,
  input logic [15:0] pulse_delay_1_i,
  input logic [1:0] chan_run_i,
  input logic [1:0] tb_trig_i,
  input logic [1:0] pulse_gen_i,
  input logic [1:0] busy_i,
  input logic [1:0] sat_i,
  output logic [1:0] trig_allow_o,
  output logic [1:0] analog_inhibit_o,
  output logic [1:0] ext_trig_o,
  output logic [1:0] dout_o
);

  // ---------------------------------------------------------------
  // Per-channel views of the configuration
  // ---------------------------------------------------------------
  // Index 0 serves emulation channel one, index 1 channel two, and each
  // input and output keeps its own selection.
  dior_pkg::dior_in_mode_t in_mode [dior_pkg::DIOR_NCH];
  dior_pkg::dior_out_sel_t out_sel [dior_pkg::DIOR_NCH];
  logic [dior_pkg::DIOR_CNT_W-1:0] out_dly [dior_pkg::DIOR_NCH];

  assign in_mode[0] = din_mode_0_i;
  assign in_mode[1] = din_mode_1_i;
  assign out_sel[0] = dout_sel_0_i;
  assign out_sel[1] = dout_sel_1_i;
  assign out_dly[0] = pulse_delay_0_i;
  assign out_dly[1] = pulse_delay_1_i;

  dior_pkg::dior_state_t q;
  dior_pkg::dior_state_t d;

  // ---------------------------------------------------------------
  // Next-state logic
  // ---------------------------------------------------------------
  // All channels share one process; the loop replicates the logic per
  // channel. Only sync2 and later stages are looked at, so the first
  // synchroniser stage feeds nothing but the second.
  always_comb begin
    logic lvl;
    logic rise;
    logic evt;
    logic idle;
    logic fire;
    logic ev_sel;
    lvl = 1'b0;
    rise = 1'b0;
    evt = 1'b0;
    idle = 1'b0;
    fire = 1'b0;
    ev_sel = 1'b0;
    d = q;
    for (int c = 0; c < dior_pkg::DIOR_NCH; c++) begin
      // Two flip-flops before any use of the pin.
      d.sync1[c] = din_i[c];
      d.sync2[c] = q.sync1[c];
      d.prev[c] = q.sync2[c];
      // A disabled input reads as idle low, whatever the pin does.
      lvl = q.sync2[c] && (in_mode[c] != dior_pkg::DIOR_IN_OFF);
      // Only the low to high transition counts as an event.
      rise = q.sync2[c] && !q.prev[c];

      // Gate: internal triggers pass only while the input is high.
      d.allow[c] = (in_mode[c] == dior_pkg::DIOR_IN_GATE) ? lvl : 1'b1;
      // Veto: the analog output is held off while the input is high.
      d.inhibit[c] = (in_mode[c] == dior_pkg::DIOR_IN_VETO) && lvl;
      // Trigger: one start pulse per rising edge of the input.
      d.ext_trig[c] = (in_mode[c] == dior_pkg::DIOR_IN_TRIG) && rise;

      // Event source for the pulse-type selections.
      ev_sel = (out_sel[c] == dior_pkg::DIOR_OUT_RAW) ||
               (out_sel[c] == dior_pkg::DIOR_OUT_ACC);
      if (out_sel[c] == dior_pkg::DIOR_OUT_RAW) begin
        evt = tb_trig_i[c];
      end else if (out_sel[c] == dior_pkg::DIOR_OUT_ACC) begin
        evt = pulse_gen_i[c];
      end else begin
        evt = 1'b0;
      end
      idle = !q.dly_busy[c] && (q.wid_cnt[c] == dior_pkg::DIOR_CNT_ZERO);

      // Delay stage; events that arrive while a pulse is pending or
      // running are dropped rather than queued, so no storage is needed.
      fire = 1'b0;
      if (q.dly_busy[c]) begin
        if (q.dly_cnt[c] <= dior_pkg::DIOR_CNT_ONE) begin
          d.dly_busy[c] = 1'b0;
          d.dly_cnt[c] = dior_pkg::DIOR_CNT_ZERO;
          fire = 1'b1;
        end else begin
          d.dly_cnt[c] = q.dly_cnt[c] - dior_pkg::DIOR_CNT_ONE;
        end
      end else if (evt && idle) begin
        if (out_dly[c] == dior_pkg::DIOR_CNT_ZERO) begin
          fire = 1'b1;
        end else begin
          d.dly_busy[c] = 1'b1;
          d.dly_cnt[c] = out_dly[c];
        end
      end

      // Width stage, counted in clock cycles.
      if (fire) begin
        d.wid_cnt[c] = (pulse_width_i < dior_pkg::DIOR_WIDTH_MIN) ?
                       dior_pkg::DIOR_WIDTH_MIN : pulse_width_i;
      end else if (q.wid_cnt[c] != dior_pkg::DIOR_CNT_ZERO) begin
        d.wid_cnt[c] = q.wid_cnt[c] - dior_pkg::DIOR_CNT_ONE;
      end

      // Leaving a pulse selection abandons whatever was in flight.
      if (!ev_sel) begin
        d.dly_busy[c] = 1'b0;
        d.dly_cnt[c] = dior_pkg::DIOR_CNT_ZERO;
        d.wid_cnt[c] = dior_pkg::DIOR_CNT_ZERO;
      end

      // Output multiplexer.
      case (out_sel[c])
        dior_pkg::DIOR_OUT_OFF: d.dout[c] = 1'b0;
        dior_pkg::DIOR_OUT_RUN: d.dout[c] = chan_run_i[c];
        dior_pkg::DIOR_OUT_RAW: begin
          d.dout[c] = d.wid_cnt[c] != dior_pkg::DIOR_CNT_ZERO;
        end
        dior_pkg::DIOR_OUT_ACC: begin
          d.dout[c] = d.wid_cnt[c] != dior_pkg::DIOR_CNT_ZERO;
        end
        dior_pkg::DIOR_OUT_BUSY: d.dout[c] = busy_i[c];
        dior_pkg::DIOR_OUT_SAT: d.dout[c] = sat_i[c];
        dior_pkg::DIOR_OUT_INPUT_TO_OUTPUT_LOOPBACK: begin
          d.dout[c] = lvl;
        end
        default: d.dout[c] = 1'b0;
      endcase
    end
  end

  // ---------------------------------------------------------------
  // State register
  // ---------------------------------------------------------------
  // Everything resets low so that every line idles low.
  always_ff @(posedge sys_clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      q <= dior_pkg::DIOR_STATE_RST;
    end else begin
      q <= d;
    end
  end

  // Outputs come straight from the state flops.
  assign trig_allow_o = q.allow;
  assign analog_inhibit_o = q.inhibit;
  assign ext_trig_o = q.ext_trig;
  assign dout_o = q.dout;

  // ---------------------------------------------------------------
  // Checks
  // ---------------------------------------------------------------
  // The checks assume the configuration ports stay steady while a
  // pulse is in flight; leaving a pulse selection mid-pulse cancels it by design.
  for (genvar g = 0; g < dior_pkg::DIOR_NCH; g++) begin : g_chk

    property p_in_off;
      @(posedge sys_clk_i) disable iff (!rst_b_i)
      (in_mode[g] == dior_pkg::DIOR_IN_OFF) |=>
        (trig_allow_o[g] && !analog_inhibit_o[g] && !ext_trig_o[g]);
    endproperty
    a_in_off: assert property (p_in_off)
      else $error("disabled input still acts");

    property p_gate;
      @(posedge sys_clk_i) disable iff (!rst_b_i)
      (in_mode[g] == dior_pkg::DIOR_IN_GATE && !din_i[g])[*4] |->
        !trig_allow_o[g];
    endproperty
    a_gate: assert property (p_gate)
      else $error("gate open while input low");

    property p_veto;
      @(posedge sys_clk_i) disable iff (!rst_b_i)
      (in_mode[g] == dior_pkg::DIOR_IN_VETO && din_i[g])[*4] |->
        analog_inhibit_o[g];
    endproperty
    a_veto: assert property (p_veto)
      else $error("veto input high but output not inhibited");

    property p_ext_trig;
      @(posedge sys_clk_i) disable iff (!rst_b_i)
      ($rose(din_i[g]) && in_mode[g] == dior_pkg::DIOR_IN_TRIG)
        ##1 (in_mode[g] == dior_pkg::DIOR_IN_TRIG)[*2] |=>
        (ext_trig_o[g] ##1 !ext_trig_o[g]);
    endproperty
    a_ext_trig: assert property (p_ext_trig)
      else $error("rising input edge gave no single start pulse");

    property p_width;
      @(posedge sys_clk_i) disable iff (!rst_b_i)
      ($rose(dout_o[g]) && pulse_width_i == 16'h0002 &&
       $past(pulse_width_i) == 16'h0002 &&
       (out_sel[g] == dior_pkg::DIOR_OUT_RAW ||
        out_sel[g] == dior_pkg::DIOR_OUT_ACC)) |->
        (dout_o[g][*2] ##1 !dout_o[g]);
    endproperty
    a_width: assert property (p_width)
      else $error("output pulse length differs from programmed width");

    property p_out_off;
      @(posedge sys_clk_i) disable iff (!rst_b_i)
      (out_sel[g] == dior_pkg::DIOR_OUT_OFF) |=> !dout_o[g];
    endproperty
    a_out_off: assert property (p_out_off)
      else $error("disabled output not low");

    property p_run;
      @(posedge sys_clk_i) disable iff (!rst_b_i)
      (out_sel[g] == dior_pkg::DIOR_OUT_RUN) |=>
        (dout_o[g] == $past(chan_run_i[g]));
    endproperty
    a_run: assert property (p_run)
      else $error("run output does not follow channel state");

    property p_raw;
      @(posedge sys_clk_i) disable iff (!rst_b_i)
      (out_sel[g] == dior_pkg::DIOR_OUT_RAW && tb_trig_i[g] &&
       !q.dly_busy[g] && q.wid_cnt[g] == dior_pkg::DIOR_CNT_ZERO &&
       out_dly[g] == dior_pkg::DIOR_CNT_ZERO) |=> dout_o[g];
    endproperty
    a_raw: assert property (p_raw)
      else $error("time-base event gave no output pulse");

    property p_acc;
      @(posedge sys_clk_i) disable iff (!rst_b_i)
      (out_sel[g] == dior_pkg::DIOR_OUT_ACC && pulse_gen_i[g] &&
       !q.dly_busy[g] && q.wid_cnt[g] == dior_pkg::DIOR_CNT_ZERO &&
       out_dly[g] == dior_pkg::DIOR_CNT_ZERO) |=> dout_o[g];
    endproperty
    a_acc: assert property (p_acc)
      else $error("generated pulse gave no accepted output pulse");

    property p_busy;
      @(posedge sys_clk_i) disable iff (!rst_b_i)
      (out_sel[g] == dior_pkg::DIOR_OUT_BUSY) |=>
        (dout_o[g] == $past(busy_i[g]));
    endproperty
    a_busy: assert property (p_busy)
      else $error("busy output does not follow busy state");

    property p_sat;
      @(posedge sys_clk_i) disable iff (!rst_b_i)
      (out_sel[g] == dior_pkg::DIOR_OUT_SAT) |=>
        (dout_o[g] == $past(sat_i[g]));
    endproperty
    a_sat: assert property (p_sat)
      else $error("saturation output does not follow clipping");

    property p_loop;
      @(posedge sys_clk_i) disable iff (!rst_b_i)
      (out_sel[g] == dior_pkg::DIOR_OUT_INPUT_TO_OUTPUT_LOOPBACK &&
       in_mode[g] != dior_pkg::DIOR_IN_OFF && din_i[g])[*4] |->
        dout_o[g];
    endproperty
    a_loop: assert property (p_loop)
      else $error("loopback output does not copy input");

    // An input held low for four cycles must not show up as a high loopback output.
    property p_loop_low;
      @(posedge sys_clk_i) disable iff (!rst_b_i)
      (out_sel[g] == dior_pkg::DIOR_OUT_INPUT_TO_OUTPUT_LOOPBACK &&
       !din_i[g])[*4] |-> !dout_o[g];
    endproperty
    a_loop_low: assert property (p_loop_low)
      else $error("loopback output high while input low");

    // Start pulses come only from an input that is in trigger mode.
    property p_no_trig;
      @(posedge sys_clk_i) disable iff (!rst_b_i)
      (in_mode[g] != dior_pkg::DIOR_IN_TRIG) |=> !ext_trig_o[g];
    endproperty
    a_no_trig: assert property (p_no_trig)
      else $error("start pulse outside trigger mode");

    property p_delay;
      @(posedge sys_clk_i) disable iff (!rst_b_i)
      (((out_sel[g] == dior_pkg::DIOR_OUT_RAW && tb_trig_i[g]) ||
        (out_sel[g] == dior_pkg::DIOR_OUT_ACC && pulse_gen_i[g])) &&
       !q.dly_busy[g] && q.wid_cnt[g] == dior_pkg::DIOR_CNT_ZERO &&
       out_dly[g] == 16'h0003) |=> (!dout_o[g])[*3] ##1 dout_o[g];
    endproperty
    a_delay: assert property (p_delay)
      else $error("output pulse not delayed by programmed amount");

    c_ext_trig: cover property (@(posedge sys_clk_i) ext_trig_o[g]);
    c_veto: cover property (@(posedge sys_clk_i) analog_inhibit_o[g]);
    c_pulse: cover property (@(posedge sys_clk_i)
      $fell(dout_o[g]) && out_sel[g] == dior_pkg::DIOR_OUT_ACC);
    c_loop: cover property (@(posedge sys_clk_i) dout_o[g] &&
      out_sel[g] == dior_pkg::DIOR_OUT_INPUT_TO_OUTPUT_LOOPBACK);
  end

endmodule // dior_router

// >>> verilog/dior_pkg.sv
// Contract
// - Lines idle low; rising edge is active.
// - Disabled input ignores all line activity.
// - Gate mode ANDs internal trigger with input.
// - Veto mode suppresses analog output while asserted.
// - Trigger mode starts generation on rising edge.
// - Event outputs pulse for programmed width.
// - Disabled output is held low.
// - Run selection reflects channel activity.
// - Raw selection pulses on each time-base event that finds it idle.
// - Accepted selection pulses once per generated pulse that finds it idle.
// - Busy selection high while engines exhausted.
// - Saturation selection high while output clipped.
// - Loopback copies digital input onto output.
// - Per-output programmable delay before output pulse.
package dior_pkg;

  // ---------------------------------------------------------------
  // Sizes and counts
  // ---------------------------------------------------------------
  localparam int DIOR_NCH = 2;
  localparam int DIOR_CNT_W = 16;
  // Shortest pulse; a programmed width of zero still gives one cycle.
  localparam logic [DIOR_CNT_W-1:0] DIOR_WIDTH_MIN = 16'h0001;
  localparam logic [DIOR_CNT_W-1:0] DIOR_CNT_ZERO = 16'h0000;
  localparam logic [DIOR_CNT_W-1:0] DIOR_CNT_ONE = 16'h0001;

  // ---------------------------------------------------------------
  // Function selections
  // ---------------------------------------------------------------
  typedef enum logic [1:0] {
    DIOR_IN_OFF = 2'b00,
    DIOR_IN_GATE = 2'b01,
    DIOR_IN_VETO = 2'b10,
    DIOR_IN_TRIG = 2'b11
  } dior_in_mode_t;

  typedef enum logic [2:0] {
    DIOR_OUT_OFF = 3'b000,
    DIOR_OUT_RUN = 3'b001,
    DIOR_OUT_RAW = 3'b010,
    DIOR_OUT_ACC = 3'b011,
    DIOR_OUT_BUSY = 3'b100,
    DIOR_OUT_SAT = 3'b101,
    DIOR_OUT_INPUT_TO_OUTPUT_LOOPBACK = 3'b110
  } dior_out_sel_t;

  // ---------------------------------------------------------------
  // Whole state of the router
  // ---------------------------------------------------------------
  typedef struct packed {
    logic [DIOR_NCH-1:0] sync1;
    logic [DIOR_NCH-1:0] sync2;
    logic [DIOR_NCH-1:0] prev;
    logic [DIOR_NCH-1:0] allow;
    logic [DIOR_NCH-1:0] inhibit;
    logic [DIOR_NCH-1:0] ext_trig;
    logic [DIOR_NCH-1:0] dout;
    logic [DIOR_NCH-1:0] dly_busy;
    logic [DIOR_NCH-1:0][DIOR_CNT_W-1:0] dly_cnt;
    logic [DIOR_NCH-1:0][DIOR_CNT_W-1:0] wid_cnt;
  } dior_state_t;

  localparam dior_state_t DIOR_STATE_RST = '0;

endpackage

// >>> verification/dior_ext_instr.sv
`timescale 1ns/1ps
// ---------------------------------------------------------------
// External instrument driving the two digital input lines
// ---------------------------------------------------------------
module dior_ext_instr (
  input wire logic clk_i,
  output logic [1:0] din_o
);
  // Lines rest low until the instrument asserts them.
  initial begin
    din_o = 2'h0;
  end

  // Levels change 1 ns after the next clock edge, like a real source,
  // so the new level is first sampled one edge later.
  task automatic drive(input logic [1:0] lvl);
    @(posedge clk_i);
    #1;
    din_o = lvl;
  endtask
endmodule // dior_ext_instr

// >>> verification/tb_dior_router.sv
`timescale 1ns/1ps
module tb_dior_router;
  // ---------------------------------------------------------------
  // Stimulus and observed signals
  // ---------------------------------------------------------------
  logic sys_clk = 1'b0;
  logic rst_b = 1'b0;
  logic [1:0] din;
  dior_pkg::dior_in_mode_t mode0 = dior_pkg::DIOR_IN_OFF;
  dior_pkg::dior_in_mode_t mode1 = dior_pkg::DIOR_IN_OFF;
  dior_pkg::dior_out_sel_t sel0 = dior_pkg::DIOR_OUT_OFF;
  dior_pkg::dior_out_sel_t sel1 = dior_pkg::DIOR_OUT_OFF;
  logic [15:0] width = 16'h0000;
  logic [15:0] dly0 = 16'h0000;
  logic [15:0] dly1 = 16'h0000;
  logic [1:0] run = 2'h0;
  logic [1:0] trig = 2'h0;
  logic [1:0] pgen = 2'h0;
  logic [1:0] busy = 2'h0;
  logic [1:0] sat = 2'h0;
  logic [1:0] allow;
  logic [1:0] inh;
  logic [1:0] etrig;
  logic [1:0] dout;
  int fail_count = 0;
  int checks_done = 0;

  // Clock at 200 MHz.
  initial begin
    forever #2.5 sys_clk = ~sys_clk;
  end

  dior_ext_instr u_dior_ext_instr (.clk_i(sys_clk), .din_o(din));

  dior_router u_dior_router (
    .sys_clk_i(sys_clk), .rst_b_i(rst_b), .din_i(din),
    .din_mode_0_i(mode0), .din_mode_1_i(mode1),
    .dout_sel_0_i(sel0), .dout_sel_1_i(sel1),
    .pulse_width_i(width), .pulse_delay_0_i(dly0),
    .pulse_delay_1_i(dly1), .chan_run_i(run), .tb_trig_i(trig),
    .pulse_gen_i(pgen), .busy_i(busy), .sat_i(sat),
    .trig_allow_o(allow), .analog_inhibit_o(inh),
    .ext_trig_o(etrig), .dout_o(dout)
  );

  // ---------------------------------------------------------------
  // Helpers
  // ---------------------------------------------------------------
  // Inputs move 1 ns after the edge so no race with the sampling edge.
  task automatic tick(input int n);
    repeat (n) begin
      @(posedge sys_clk);
      #1;
    end
  endtask

  task automatic chk(input logic [1:0] got, input logic [1:0] exp,
                     input string m);
    checks_done++;
    if (got !== exp) begin
      fail_count++;
      $display("CHECK FAILED t=%0t %s got %b exp %b", $time, m, got, exp);
    end
  endtask

  task automatic finish_test;
    $display("checks %0d failures %0d", checks_done, fail_count);
    if (fail_count == 0 && checks_done > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask

  // A hung run is cut short well past the expected 45 cycles.
  initial begin
    #20000;
    fail_count++;
    finish_test();
  end

  // ---------------------------------------------------------------
  // Main sequence
  // ---------------------------------------------------------------
  initial begin
    tick(10);
    rst_b = 1'b1;
    // Disabled outputs stay low although the run, saturation and busy sources are active.
    run = 2'h3;
    sat = 2'h3;
    busy = 2'h3;
    tick(2);
    chk(dout, 2'h0, "off");
    // Level selections, each output with its own choice.
    sel0 = dior_pkg::DIOR_OUT_RUN;
    sel1 = dior_pkg::DIOR_OUT_SAT;
    run = 2'h1;
    sat = 2'h2;
    tick(1);
    chk(dout, 2'h3, "run sat");
    run = 2'h2;
    tick(1);
    chk(dout, 2'h2, "run off");
    sel0 = dior_pkg::DIOR_OUT_BUSY;
    sel1 = dior_pkg::DIOR_OUT_BUSY;
    busy = 2'h2;
    tick(1);
    chk(dout, 2'h2, "busy");
    // Raw events back to back: the second falls inside the pulse.
    sel0 = dior_pkg::DIOR_OUT_RAW;
    sel1 = dior_pkg::DIOR_OUT_OFF;
    width = 16'h0002;
    trig = 2'h1;
    tick(1);
    chk(dout, 2'h1, "raw c1");
    tick(1);
    trig = 2'h0;
    chk(dout, 2'h1, "raw c2");
    tick(1);
    chk(dout, 2'h0, "raw end");
    tick(1);
    chk(dout, 2'h0, "no retrig");
    // Accepted pulses with width 0, which still gives one cycle: output 1
    // fires at once, output 2 after a delay of 3.
    sel0 = dior_pkg::DIOR_OUT_ACC;
    sel1 = dior_pkg::DIOR_OUT_ACC;
    width = 16'h0000;
    dly1 = 16'h0003;
    pgen = 2'h3;
    tick(1);
    pgen = 2'h0;
    chk(dout, 2'h1, "dly c1");
    tick(2);
    chk(dout, 2'h0, "dly c3");
    tick(1);
    chk(dout, 2'h2, "acc");
    tick(1);
    chk(dout, 2'h0, "acc end");
    // Input 1 disabled, input 2 gating, both looped back. Each level is
    // held past the sync latency so that settled values are compared.
    mode1 = dior_pkg::DIOR_IN_GATE;
    sel0 = dior_pkg::DIOR_OUT_INPUT_TO_OUTPUT_LOOPBACK;
    sel1 = dior_pkg::DIOR_OUT_INPUT_TO_OUTPUT_LOOPBACK;
    tick(1);
    chk(allow, 2'h1, "gate low");
    tick(2);
    u_dior_ext_instr.drive(2'h3);
    tick(4);
    chk(allow, 2'h3, "gate high");
    chk(dout, 2'h2, "loop");
    chk(etrig | inh, 2'h0, "off quiet");
    u_dior_ext_instr.drive(2'h0);
    tick(3);
    chk(allow, 2'h1, "gate drop");
    chk(dout, 2'h0, "loop low");
    // Veto on input 1, external trigger on input 2.
    mode0 = dior_pkg::DIOR_IN_VETO;
    mode1 = dior_pkg::DIOR_IN_TRIG;
    u_dior_ext_instr.drive(2'h3);
    tick(2);
    chk(etrig, 2'h0, "trig early");
    tick(1);
    chk(etrig, 2'h2, "trig");
    chk(inh, 2'h1, "veto");
    tick(1);
    chk(etrig, 2'h0, "trig once");
    chk(inh, 2'h1, "veto held");
    u_dior_ext_instr.drive(2'h0);
    tick(3);
    chk(inh, 2'h0, "veto off");
    finish_test();
  end
endmodule // tb_dior_router
